// ### rtl/secfuse_pkg.sv
/*
 * security state package: fuse bits, counter steps, access zones, structs.
 * assumes nothing of its surroundings.
 */
package secfuse_pkg;
   // ***************
   // fuse positions
   // ***************
   localparam int FAB_BIT = 0;
   localparam int CMA_BIT = 1;
   localparam int PER_BIT = 2;
   localparam int LOT_BIT = 3;
   localparam logic [3:0] FUSE_INTACT    = 4'hF;
   localparam logic [3:0] FUSE_RESV_BITS = 4'hF;
   localparam logic [3:0] FUSE_ALL_BLOWN = 4'h0;

   // ***************
   // counter values
   // ***************
   localparam logic [7:0] CNT_FULL   = 8'hFF;
   localparam logic [7:0] CNT_LOCKED = 8'h00;
   localparam logic [7:0] CNT_MASK4  = 8'hEE;

   // ***************
   // sizes
   // ***************
   localparam int N_KEYS  = 4;
   localparam int N_PWSET = 8;
   localparam int N_PW    = 16;
   localparam int KEY_W   = 64;
   localparam int PW_W    = 24;
   localparam int SEC_IDX = 15;
   localparam int STARTUP_PULSES = 5;

   // ***************
   // config memory zones
   // ***************
   typedef enum logic [2:0] {
      ZONE_IDENT  = 3'h0,
      ZONE_TEST   = 3'h1,
      ZONE_MAKER  = 3'h2,
      ZONE_LOTHST = 3'h3,
      ZONE_ACCESS = 3'h4,
      ZONE_CRYPTO = 3'h5,
      ZONE_SECRET = 3'h6,
      ZONE_PWD    = 3'h7
   } zone_e;

   typedef enum logic [2:0] {
      OP_NONE     = 3'h0,
      OP_PW_CHECK = 3'h1,
      OP_AUTH     = 3'h2,
      OP_BLOW     = 3'h3,
      OP_SKEY_UPD = 3'h4
   } op_e;

   typedef struct packed {
      logic       valid;
      op_e        op;
      logic [3:0] index;
      logic       ok;
      logic [KEY_W-1:0] data;
   } sec_req_s;

   typedef struct packed {
      logic  valid;
      zone_e zone;
      logic  write;
      logic  sec_ok;
      logic  wpw_ok;
   } cfg_req_s;
endpackage

// ### rtl/security_fuse_counter_logic.sv
/*
 * security state logic: keys, seeds, passwords, attempt counters, fuses,
 * configuration access rights and power-up protocol selection.
 * assumes a command decoder on clk_i issuing at most one request every three cycles and
 * rst_i as power-on reset; link clock and reset pins arrive unsynchronised.
 */
// Contract
// - four 64-bit session keys, updated on success
// - four 64-bit secret seeds stored
// - eight password pairs; change needs write password
// - secure code grants config write, self change
// - personalization fuse ends secure code write
// - sixteen password counters step ff ee cc 88 00
// - password locks at zero; pass restores ff
// - four auth counters, same stepping
// - auth key set locks at zero; pass restores
// - fuse byte bits 0-3, zero means blown
// - blown fuse never restored; rst_i reloads all four fuses intact
// - fuses blown fab, maker, personalization order
// - fab, maker and personalization fuses lock their config areas; lot fuse locks none
// - identification writable by secure code pre-fab
// - crypto area writable until personalization fuse
// - user zones governed by access registers only
// - reset high at power-up selects two-wire
// - reset low on rising clock selects async
// - async mode sticks until power cycle
// - eight-trials bit zero allows eight failures
`timescale 1ns/1ps
module security_fuse_counter_logic (
   input  wire logic                  clk_i,        // 40 MHz core clock
   input  wire logic                  rst_i,        // power-on reset
   input  wire logic                  link_clk_i,   // link clock pin
   input  wire logic                  card_rst_i,   // reset pin
   input  wire logic                  eight_trials_bit_i, // 0 = eight tries
   input  wire secfuse_pkg::sec_req_s req_i,        // security request
   input  wire secfuse_pkg::cfg_req_s cfg_i,        // config access query
   output logic                       req_done_o,   // request finished
   output logic                       req_ok_o,     // request granted
   output logic                       cfg_grant_o,  // config access allowed
   output logic                 [7:0] security_fuse_status_o, // fuse byte
   output logic                       async_mode_o, // smart-card mode
   output logic                       link_ready_o, // startup pulses seen
   output logic                       sec_code_ok_o,// secure code verified and personalization fuse intact
   output logic                [63:0] session_key_o,// key of last index
   output logic                 [7:0] cnt_view_o    // counter of last index
);
   // *********************************
   // state
   // *********************************
   localparam int N_PWSET_W = secfuse_pkg::N_PWSET;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_COMMIT = 3'b010,
      ST_ACT    = 3'b100
   } st_e;

   typedef struct packed {
      st_e       st;
      logic [1:0] lclk_sync;
      logic [1:0] rst_sync;
      logic       lclk_prev;
      logic       mode_set;
      logic       async_mode;
      logic [2:0] pulses;
      logic [3:0] fuses;
      logic       sec_ok;
      logic [N_PWSET_W-1:0] wpw_ok;
      secfuse_pkg::sec_req_s held;
      logic       done;
      logic       ok;
      logic [63:0] key_view;
      logic [7:0]  cnt_view;
   } state_s;

   state_s s_q;
   state_s s_d;

   // nonvolatile-like storage, kept outside the struct to index cleanly
   logic [secfuse_pkg::KEY_W-1:0] session_keys [secfuse_pkg::N_KEYS];
   logic [secfuse_pkg::KEY_W-1:0] secret_seeds [secfuse_pkg::N_KEYS];
   logic [secfuse_pkg::PW_W-1:0]  read_pw      [secfuse_pkg::N_PWSET];
   logic [secfuse_pkg::PW_W-1:0]  write_pw     [secfuse_pkg::N_PWSET];
   logic [7:0] password_try_counter [secfuse_pkg::N_PW];
   logic [7:0] auth_try_counter     [secfuse_pkg::N_KEYS];

   // *********************************
   // counter steps
   // *********************************
   logic [7:0] pw_next;
   logic [7:0] au_next;
   logic       pw_lock;
   logic       au_lock;
   logic       is_pw;
   logic       is_au;

   assign is_pw = (s_q.held.op == secfuse_pkg::OP_PW_CHECK);
   assign is_au = (s_q.held.op == secfuse_pkg::OP_AUTH);

   try_counter_step u_pw_step (
      .cnt_i    (password_try_counter[s_q.held.index]),
      .fail_i   (!s_q.held.ok),
      .pass_i   (s_q.held.ok),
      .eight_i  (!eight_trials_bit_i),
      .cnt_o    (pw_next),
      .locked_o (pw_lock)
   );

   try_counter_step u_au_step (
      .cnt_i    (auth_try_counter[s_q.held.index[1:0]]),
      .fail_i   (!s_q.held.ok),
      .pass_i   (s_q.held.ok),
      .eight_i  (!eight_trials_bit_i),
      .cnt_o    (au_next),
      .locked_o (au_lock)
   );

   // *********************************
   // fuse order
   // *********************************
   logic blow_legal;
   logic [3:0] blow_mask;
   always_comb begin
      blow_mask  = 4'h0;
      blow_mask[s_q.held.index[1:0]] = 1'b1;
      // maker and personalization fuses need the previous fuse blown; lot fuse can be blown any time
      case (s_q.held.index[1:0])
         2'h0:    blow_legal = 1'b1;
         2'h1:    blow_legal = !s_q.fuses[secfuse_pkg::FAB_BIT];
         2'h2:    blow_legal = !s_q.fuses[secfuse_pkg::CMA_BIT];
         default: blow_legal = 1'b1;
      endcase
   end

   // *********************************
   // next state
   // *********************************
   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.lclk_sync = {s_q.lclk_sync[0], link_clk_i};
      s_d.rst_sync  = {s_q.rst_sync[0], card_rst_i};
      s_d.lclk_prev = s_q.lclk_sync[1];
      if (s_q.lclk_sync[1] && !s_q.lclk_prev) begin
         if (!s_q.mode_set) begin
            s_d.mode_set   = 1'b1;
            s_d.async_mode = !s_q.rst_sync[1];
         end
         if (s_q.pulses < 3'(secfuse_pkg::STARTUP_PULSES)) begin
            s_d.pulses = s_q.pulses + 3'h1;
         end
      end
      case (s_q.st)
         ST_IDLE: begin
            if (req_i.valid) begin
               s_d.held = req_i;
               s_d.st   = ST_COMMIT;
            end
         end
         ST_COMMIT: begin
            // counter written here, before the outcome is acted on
            s_d.st = ST_ACT;
         end
         ST_ACT: begin
            s_d.st   = ST_IDLE;
            s_d.done = 1'b1;
            s_d.ok   = 1'b0;
            case (s_q.held.op)
               secfuse_pkg::OP_PW_CHECK: begin
                  s_d.ok = s_q.held.ok && !pw_lock;
                  if (s_d.ok && s_q.held.index[3:0] == 4'(secfuse_pkg::SEC_IDX))
                     s_d.sec_ok = 1'b1;
                  if (s_d.ok && !s_q.held.index[3])
                     s_d.wpw_ok[s_q.held.index[2:0]] = 1'b1;
               end
               secfuse_pkg::OP_AUTH: s_d.ok = s_q.held.ok && !au_lock;
               secfuse_pkg::OP_BLOW: begin
                  s_d.ok = blow_legal;
                  if (blow_legal)
                     s_d.fuses = s_q.fuses & ~blow_mask;
               end
               secfuse_pkg::OP_SKEY_UPD: s_d.ok = 1'b1;
               default: s_d.ok = 1'b0;
            endcase
            // counter storage already holds this outcome; stepping again would skip a value; a new session key comes from held.data
            s_d.key_view = session_keys[s_q.held.index[1:0]];
            if (s_q.held.ok
                && ((is_au && !au_lock) || s_q.held.op == secfuse_pkg::OP_SKEY_UPD))
               s_d.key_view = s_q.held.data;
            s_d.cnt_view = is_au ? auth_try_counter[s_q.held.index[1:0]]
                                 : password_try_counter[s_q.held.index];
         end
         default: s_d.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_q <= '{st: ST_IDLE, fuses: secfuse_pkg::FUSE_INTACT, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   // *********************************
   // storage updates
   // *********************************
   for (genvar i = 0; i < secfuse_pkg::N_PW; i++) begin : g_pac
      always_ff @(posedge clk_i or posedge rst_i) begin
         if (rst_i) begin
            password_try_counter[i] <= secfuse_pkg::CNT_FULL;
         end else if (s_q.st == ST_COMMIT && is_pw && s_q.held.index == 4'(i)) begin
            password_try_counter[i] <= pw_next;
         end
      end
   end

   for (genvar k = 0; k < secfuse_pkg::N_KEYS; k++) begin : g_key
      always_ff @(posedge clk_i or posedge rst_i) begin
         if (rst_i) begin
            auth_try_counter[k] <= secfuse_pkg::CNT_FULL;
            session_keys[k]     <= '0;
            secret_seeds[k]     <= '0;
         end else begin
            if (s_q.st == ST_COMMIT && is_au && s_q.held.index[1:0] == 2'(k))
               auth_try_counter[k] <= au_next;
            if (s_q.st == ST_ACT && s_q.held.ok && s_q.held.index[1:0] == 2'(k)
                && ((is_au && !au_lock) || s_q.held.op == secfuse_pkg::OP_SKEY_UPD))
               session_keys[k] <= s_q.held.data;
            if (cfg_i.valid && cfg_grant_o && cfg_i.write
                && cfg_i.zone == secfuse_pkg::ZONE_SECRET && s_q.held.index[1:0] == 2'(k))
               secret_seeds[k] <= s_q.held.data;
         end
      end
   end

   for (genvar p = 0; p < secfuse_pkg::N_PWSET; p++) begin : g_pw
      always_ff @(posedge clk_i or posedge rst_i) begin
         if (rst_i) begin
            read_pw[p]  <= '1;
            write_pw[p] <= '1;
         end else if (cfg_i.valid && cfg_i.write && cfg_i.zone == secfuse_pkg::ZONE_PWD
                      && s_q.wpw_ok[p] && s_q.held.index[2:0] == 3'(p)) begin
            read_pw[p]  <= s_q.held.data[secfuse_pkg::PW_W-1:0];
            write_pw[p] <= s_q.held.data[2*secfuse_pkg::PW_W-1:secfuse_pkg::PW_W];
         end
      end
   end

   // *********************************
   // config access rights
   // *********************************
   logic sc_live;
   assign sc_live = s_q.sec_ok && s_q.fuses[secfuse_pkg::PER_BIT];
   always_comb begin
      cfg_grant_o = 1'b0;
      if (cfg_i.valid) begin
         if (!cfg_i.write) begin
            cfg_grant_o = !(cfg_i.zone inside {secfuse_pkg::ZONE_SECRET, secfuse_pkg::ZONE_PWD})
                          || sc_live;
         end else begin
            case (cfg_i.zone)
               secfuse_pkg::ZONE_IDENT:
                  cfg_grant_o = sc_live && s_q.fuses[secfuse_pkg::FAB_BIT];
               secfuse_pkg::ZONE_TEST:   cfg_grant_o = 1'b1;
               secfuse_pkg::ZONE_MAKER:
                  cfg_grant_o = sc_live && s_q.fuses[secfuse_pkg::CMA_BIT];
               secfuse_pkg::ZONE_LOTHST: cfg_grant_o = 1'b0;
               secfuse_pkg::ZONE_PWD:
                  cfg_grant_o = sc_live || s_q.wpw_ok != '0;
               default: cfg_grant_o = sc_live;
            endcase
         end
      end
   end
   // user zones are decided by access registers elsewhere, never by fuses

   // *********************************
   // outputs
   // *********************************
   assign req_done_o    = s_q.done;
   assign req_ok_o      = s_q.ok;
   assign security_fuse_status_o = {secfuse_pkg::FUSE_RESV_BITS, s_q.fuses};
   assign async_mode_o  = s_q.async_mode;
   assign link_ready_o  = s_q.pulses == 3'(secfuse_pkg::STARTUP_PULSES);
   assign sec_code_ok_o = sc_live;
   assign session_key_o = s_q.key_view;
   assign cnt_view_o    = s_q.cnt_view;

   // *********************************
   // assertions
   // *********************************
   property p_fuse_once;
      @(posedge clk_i) disable iff (rst_i)
      (s_q.fuses != $past(s_q.fuses)) |-> ((s_q.fuses & ~$past(s_q.fuses)) == 4'h0);
   endproperty
   a_fuse_once: assert property (p_fuse_once) else $error("fuse restored");

   property p_order;
      @(posedge clk_i) disable iff (rst_i)
      !s_q.fuses[secfuse_pkg::PER_BIT] |-> !s_q.fuses[secfuse_pkg::CMA_BIT]
                                       && !s_q.fuses[secfuse_pkg::FAB_BIT];
   endproperty
   a_order: assert property (p_order) else $error("fuse order broken");

   property p_async_stick;
      @(posedge clk_i) disable iff (rst_i)
      async_mode_o |=> async_mode_o;
   endproperty
   a_async_stick: assert property (p_async_stick) else $error("left async mode");

   property p_per_lock;
      @(posedge clk_i) disable iff (rst_i)
      (cfg_i.valid && cfg_i.write && cfg_i.zone == secfuse_pkg::ZONE_CRYPTO
       && !s_q.fuses[secfuse_pkg::PER_BIT]) |-> !cfg_grant_o;
   endproperty
   a_per_lock: assert property (p_per_lock) else $error("write after pers fuse");

   property p_ident;
      @(posedge clk_i) disable iff (rst_i)
      (cfg_i.valid && cfg_i.write && cfg_i.zone == secfuse_pkg::ZONE_IDENT
       && !s_q.fuses[secfuse_pkg::FAB_BIT]) |-> !cfg_grant_o;
   endproperty
   a_ident: assert property (p_ident) else $error("ident write after fab");

   property p_status;
      @(posedge clk_i) disable iff (rst_i)
      security_fuse_status_o[7:4] == secfuse_pkg::FUSE_RESV_BITS;
   endproperty
   a_status: assert property (p_status) else $error("reserved bits wrong");

   property p_commit;
      @(posedge clk_i) disable iff (rst_i)
      (s_q.st == ST_IDLE && req_i.valid) |-> ##3 req_done_o;
   endproperty
   a_commit: assert property (p_commit) else $error("request not finished");

   property p_pw_fail;
      @(posedge clk_i) disable iff (rst_i)
      (s_q.st == ST_COMMIT && is_pw && !s_q.held.ok && !pw_lock && eight_trials_bit_i)
      |=> (password_try_counter[$past(s_q.held.index)] ==
           ($past(password_try_counter[s_q.held.index])
            & (($past(password_try_counter[s_q.held.index]) << 1) & secfuse_pkg::CNT_MASK4))
           && password_try_counter[$past(s_q.held.index)]
              != $past(password_try_counter[s_q.held.index]));
   endproperty
   a_pw_fail: assert property (p_pw_fail) else $error("password count step wrong");

   c_blow:  cover property (@(posedge clk_i) req_done_o && req_ok_o
                            && s_q.held.op == secfuse_pkg::OP_BLOW);
   c_async: cover property (@(posedge clk_i) async_mode_o);
   c_lock:  cover property (@(posedge clk_i) req_done_o
                            && cnt_view_o == secfuse_pkg::CNT_LOCKED);
endmodule // security_fuse_counter_logic

// ### rtl/try_counter_step.sv
/*
 * attempt counter step: next value after a wrong or right presentation.
 * assumes the caller holds the counter and the eight-trials bit.
 */
`timescale 1ns/1ps
module try_counter_step (
   input  wire logic [7:0] cnt_i,       // present counter
   input  wire logic       fail_i,      // wrong presentation
   input  wire logic       pass_i,      // correct presentation
   input  wire logic       eight_i,     // 1 = eight-step sequence
   output logic      [7:0] cnt_o,       // next counter
   output logic            locked_o     // counter at zero
);
   always_comb begin
      cnt_o    = cnt_i;
      locked_o = (cnt_i == secfuse_pkg::CNT_LOCKED);
      if (!locked_o) begin
         if (pass_i) begin
            cnt_o = secfuse_pkg::CNT_FULL;
         end else if (fail_i) begin
            if (eight_i) begin
               cnt_o = cnt_i & {cnt_i[6:0], 1'b0};
            end else begin
               // ff ee cc 88 00: shift per nibble
               cnt_o = cnt_i & {cnt_i[6:4], 1'b0, cnt_i[2:0], 1'b0};
            end
         end
      end
   end
endmodule // try_counter_step

// ### tb/host_link_model.sv
/*
 * host side of the link: drives the link clock and reset pins.
 * assumes the bench calls its tasks; the clock stands still between bursts.
 */
`timescale 1ns/1ps
module host_link_model (
   output logic link_clk_o, // link clock pin
   output logic card_rst_o  // reset pin
);
   // ***************
   // pin drive
   // ***************
   initial begin
      link_clk_o = 1'b0;
      card_rst_o = 1'b1;
   end

   // off-grid start keeps the pins unrelated in phase to the core clock
   task automatic pulses(input int n);
      int i;
      #13;
      for (i = 0; i < n; i++) begin
         link_clk_o = 1'b1;
         #100;
         link_clk_o = 1'b0;
         #100;
      end
   endtask

   task automatic set_rst(input logic v);
      card_rst_o = v;
   endtask
endmodule // host_link_model

// ### tb/tb.sv
/*
 * self-checking bench for the security state logic.
 * assumes the package is compiled first and the host model beside it.
 */
`timescale 1ns/1ps
module tb;
   localparam logic [31:0] FOUR  = 32'hEECC8800;
   localparam logic [63:0] EIGHT = 64'hFEFCF8F0E0C08000;
   logic                  clk_i;
   logic                  rst_i;
   logic                  link_clk;
   logic                  card_rst;
   logic                  eight_trials;
   secfuse_pkg::sec_req_s req;
   secfuse_pkg::cfg_req_s cfg;
   logic                  req_done;
   logic                  req_ok;
   logic                  cfg_grant;
   logic                  async_mode;
   logic                  link_ready;
   logic                  sec_code_ok;
   logic            [7:0] fuse_status;
   logic            [7:0] cnt_view;
   logic           [63:0] session_key;
   logic                  got_ok;
   logic            [7:0] got_cnt;
   int                    n_fail;
   int                    n_compared;
   int                    i;

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   host_link_model host (.link_clk_o(link_clk), .card_rst_o(card_rst));

   security_fuse_counter_logic dut (
      .clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk), .card_rst_i(card_rst),
      .eight_trials_bit_i(eight_trials), .req_i(req), .cfg_i(cfg),
      .req_done_o(req_done), .req_ok_o(req_ok), .cfg_grant_o(cfg_grant),
      .security_fuse_status_o(fuse_status), .async_mode_o(async_mode),
      .link_ready_o(link_ready), .sec_code_ok_o(sec_code_ok),
      .session_key_o(session_key), .cnt_view_o(cnt_view));

   // ***************
   // tasks
   // ***************
   task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic do_req(input secfuse_pkg::op_e op, input logic [3:0] idx, input logic ok,
                         input logic [63:0] data);
      int k;
      @(negedge clk_i);
      req = '{valid: 1'b1, op: op, index: idx, ok: ok, data: data};
      @(negedge clk_i);
      req.valid = 1'b0;
      for (k = 0; k < 12 && req_done !== 1'b1; k++) @(negedge clk_i);
      chk("req_done", 64'h1, {63'h0, req_done});
      got_ok = req_ok;
      got_cnt = cnt_view;
   endtask

   task automatic cfg_chk(input secfuse_pkg::zone_e z, input logic wr, input logic exp);
      @(negedge clk_i);
      cfg = '{valid: 1'b1, zone: z, write: wr, sec_ok: exp, wpw_ok: wr};
      #1;
      chk("cfg_grant", {63'h0, exp}, {63'h0, cfg_grant});
   endtask

   task automatic blow(input logic [3:0] f, input logic exp_ok, input logic [7:0] exp_st);
      do_req(secfuse_pkg::OP_BLOW, f, 1'b1, 64'h0);
      chk("blow_ok", {63'h0, exp_ok}, {63'h0, got_ok});
      chk("fuse_status", {56'h0, exp_st}, {56'h0, fuse_status});
   endtask

   task automatic do_reset;
      rst_i = 1'b1;
      repeat (6) @(negedge clk_i);
      rst_i = 1'b0;
   endtask

   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ***************
   // watchdog
   // ***************
   initial begin
      #2000000;
      n_fail++;
      results;
   end

   // ***************
   // main sequence
   // ***************
   initial begin
      n_fail = 0;
      n_compared = 0;
      eight_trials = 1'b1;
      req = '0;
      cfg = '0;
      do_reset;
      chk("fuse_status", 64'hFF, {56'h0, fuse_status});
      host.pulses(4);
      repeat (6) @(negedge clk_i);
      chk("link_ready", 64'h0, {63'h0, link_ready});
      host.pulses(1);
      repeat (6) @(negedge clk_i);
      chk("link_ready", 64'h1, {63'h0, link_ready});
      chk("async_mode", 64'h0, {63'h0, async_mode});
      // password counter: two misses, then a hit restores
      for (i = 0; i < 2; i++) begin
         do_req(secfuse_pkg::OP_PW_CHECK, 4'h3, 1'b0, 64'h0);
         chk("pw_cnt", {56'h0, FOUR[31-8*i -: 8]}, {56'h0, got_cnt});
      end
      do_req(secfuse_pkg::OP_PW_CHECK, 4'h3, 1'b1, 64'h0);
      chk("pw_ok", 64'h1, {63'h0, got_ok});
      chk("pw_cnt", 64'hFF, {56'h0, got_cnt});
      for (i = 0; i < 4; i++) begin
         do_req(secfuse_pkg::OP_PW_CHECK, 4'h3, 1'b0, 64'h0);
         chk("pw_cnt", {56'h0, FOUR[31-8*i -: 8]}, {56'h0, got_cnt});
      end
      do_req(secfuse_pkg::OP_PW_CHECK, 4'h3, 1'b1, 64'h0);
      chk("pw_locked_ok", 64'h0, {63'h0, got_ok});
      chk("pw_locked_cnt", 64'h0, {56'h0, got_cnt});
      // authentication counter
      do_req(secfuse_pkg::OP_AUTH, 4'h1, 1'b0, 64'h0);
      chk("auth_cnt", 64'hEE, {56'h0, got_cnt});
      do_req(secfuse_pkg::OP_AUTH, 4'h1, 1'b1, 64'h0);
      chk("auth_cnt", 64'hFF, {56'h0, got_cnt});
      for (i = 0; i < 4; i++) begin
         do_req(secfuse_pkg::OP_AUTH, 4'h1, 1'b0, 64'h0);
         chk("auth_cnt", {56'h0, FOUR[31-8*i -: 8]}, {56'h0, got_cnt});
      end
      do_req(secfuse_pkg::OP_AUTH, 4'h1, 1'b1, 64'h0);
      chk("auth_locked_ok", 64'h0, {63'h0, got_ok});
      // eight-trial stepping
      @(negedge clk_i);
      eight_trials = 1'b0;
      for (i = 0; i < 8; i++) begin
         do_req(secfuse_pkg::OP_PW_CHECK, 4'h5, 1'b0, 64'h0);
         chk("pw8_cnt", {56'h0, EIGHT[63-8*i -: 8]}, {56'h0, got_cnt});
      end
      @(negedge clk_i);
      eight_trials = 1'b1;
      do_req(secfuse_pkg::OP_SKEY_UPD, 4'h2, 1'b1, 64'h0123456789ABCDEF);
      chk("session_key", 64'h0123456789ABCDEF, session_key);
      // secure code and fuse-dependent rights
      do_req(secfuse_pkg::OP_PW_CHECK, 4'hF, 1'b1, 64'h0);
      chk("sec_code_ok", 64'h1, {63'h0, sec_code_ok});
      cfg_chk(secfuse_pkg::ZONE_IDENT, 1'b1, 1'b1);
      cfg_chk(secfuse_pkg::ZONE_IDENT, 1'b0, 1'b1);
      cfg_chk(secfuse_pkg::ZONE_CRYPTO, 1'b1, 1'b1);
      cfg_chk(secfuse_pkg::ZONE_LOTHST, 1'b1, 1'b0);
      cfg_chk(secfuse_pkg::ZONE_TEST, 1'b1, 1'b1);
      blow(4'h2, 1'b0, 8'hFF);
      blow(4'h1, 1'b0, 8'hFF);
      blow(4'h0, 1'b1, 8'hFE);
      cfg_chk(secfuse_pkg::ZONE_IDENT, 1'b1, 1'b0);
      cfg_chk(secfuse_pkg::ZONE_MAKER, 1'b1, 1'b1);
      do_req(secfuse_pkg::OP_BLOW, 4'h0, 1'b1, 64'h0);
      chk("fuse_status", 64'hFE, {56'h0, fuse_status});
      blow(4'h1, 1'b1, 8'hFC);
      cfg_chk(secfuse_pkg::ZONE_MAKER, 1'b1, 1'b0);
      cfg_chk(secfuse_pkg::ZONE_CRYPTO, 1'b1, 1'b1);
      blow(4'h2, 1'b1, 8'hF8);
      chk("sec_code_ok", 64'h0, {63'h0, sec_code_ok});
      do_req(secfuse_pkg::OP_PW_CHECK, 4'hF, 1'b1, 64'h0);
      cfg_chk(secfuse_pkg::ZONE_CRYPTO, 1'b1, 1'b0);
      cfg_chk(secfuse_pkg::ZONE_ACCESS, 1'b1, 1'b0);
      blow(4'h3, 1'b1, 8'hF0);
      // power cycle into the smart-card protocol
      host.set_rst(1'b0);
      do_reset;
      host.pulses(1);
      repeat (6) @(negedge clk_i);
      chk("async_mode", 64'h1, {63'h0, async_mode});
      host.set_rst(1'b1);
      host.pulses(5);
      repeat (6) @(negedge clk_i);
      chk("async_mode", 64'h1, {63'h0, async_mode});
      results;
   end
endmodule // tb
